// [logic/fmwg_defs.vh]
// Constants for the flash mode write guard
//
// How it works
// R01: Sequence starts only with unlock byte A5H
// R02: Value and inverse writes are ignored
// R03: Fourth write updates the mode bit
// R04: Software unlocks again for every change
// R05: Bad sequence sets protect error bit 0
// R06: Writing 0 clears protect error flag
// R07: Self-program error bits 1, 2 cleared by 0
// R08: Reset clears status register to 00H
// R09: Unlock command register needs no reset
// R10: Unlock command register takes byte writes
// R11: Status register takes bit or byte writes
// R12: Software clears status flags before operations
// R13: Software masks interrupts around self-programming
// R14: Guard returns idle after success or error
`ifndef FMWG_DEFS_VH
`define FMWG_DEFS_VH
`define FMWG_ADDR_UNLOCK 16'hffa0
`define FMWG_ADDR_MODE 16'hffa2
`define FMWG_ADDR_STATUS 16'hffa3
`define FMWG_UNLOCK_CODE 8'ha5
`define FMWG_STATUS_RESET 8'h00
`define FMWG_MODE_RESET 1'b0
`define FMWG_BIT_PROTECT 0
`define FMWG_BIT_ERR_A 1
`define FMWG_BIT_ERR_B 2
`endif

// [logic/fmwg_byte_reg.v]
// Byte register without reset, used for the unlock command register
`timescale 1ns/1ps
`default_nettype none
module fmwg_byte_reg #(
	parameter WIDTH = 8
) (
	input wire ref_clk_in,
	input wire ce_in,
	input wire wr_in,
	input wire [WIDTH-1:0] data_in,
	output reg [WIDTH-1:0] data_out
);
	// Contents undefined after reset
	always @(posedge ref_clk_in) begin
		if (ce_in && wr_in) begin
			data_out <= data_in; // see R09 R10
		end
	end
endmodule // fmwg_byte_reg
`default_nettype wire

// [logic/fmwg_guard.v]
// Flash mode write guard top level
`timescale 1ns/1ps
`default_nettype none
`include "fmwg_defs.vh"
module fmwg_guard (
	input wire ref_clk_in,
	input wire resetn_in,
	input wire ce_in,
	input wire [15:0] addr_in,
	input wire wr_in,
	input wire rd_in,
	input wire bit_wr_in,
	input wire [2:0] bit_sel_in,
	input wire [7:0] wdata_in,
	input wire self_program_error_a_in,
	input wire self_program_error_b_in,
	output reg [7:0] rdata_out,
	output reg self_program_select_out,
	output wire [1:0] seq_state_out
);
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_VAL = 4'b0010;
	localparam [3:0] ST_INV = 4'b0100;
	localparam [3:0] ST_FIN = 4'b1000;

	////////////////////////////////////////////////////////////////
	// Effective byte for byte or single-bit writes
	function [7:0] merge_byte;
		input [7:0] old;
		input bit_mode;
		input [2:0] sel;
		input [7:0] wd;
		reg [7:0] r;
		begin
			r = old;
			if (bit_mode) begin
				r[sel] = wd[0];
			end else begin
				r = wd;
			end
			merge_byte = r;
		end
	endfunction

	reg [3:0] state;
	reg [3:0] next_state;
	reg [7:0] status;
	reg first_bit;
	wire [7:0] unlock_q;
	wire wr_unlock = wr_in && (addr_in == `FMWG_ADDR_UNLOCK);
	wire wr_mode = wr_in && (addr_in == `FMWG_ADDR_MODE);
	wire wr_status = wr_in && (addr_in == `FMWG_ADDR_STATUS);
	wire [7:0] mode_byte = merge_byte({7'h00, self_program_select_out}, bit_wr_in,
		bit_sel_in, wdata_in);
	wire [7:0] stat_byte = merge_byte(status, bit_wr_in, bit_sel_in, wdata_in);
	reg seq_err;
	reg mode_commit;

	fmwg_byte_reg #(.WIDTH(8)) u_unlock (
		.ref_clk_in(ref_clk_in),
		.ce_in(ce_in),
		.wr_in(wr_unlock && !bit_wr_in), // see R10
		.data_in(wdata_in),
		.data_out(unlock_q)
	);

	assign seq_state_out = {state[2] | state[3], state[1] | state[3]};

	////////////////////////////////////////////////////////////////
	// Sequence checker
	always @* begin
		next_state = state;
		seq_err = 1'b0;
		mode_commit = 1'b0;
		case (state)
			ST_IDLE: begin
				if (wr_unlock && !bit_wr_in && wdata_in == `FMWG_UNLOCK_CODE) begin
					next_state = ST_VAL; // see R01
				end else if (wr_mode) begin
					seq_err = 1'b1; // see R01 R05
				end
			end
			ST_VAL: begin
				// Stored command byte must still hold the unlock code
				if (wr_mode && unlock_q == `FMWG_UNLOCK_CODE) begin
					next_state = ST_INV; // see R02
				end else if (wr_mode || wr_unlock) begin
					seq_err = 1'b1;
					next_state = ST_IDLE; // see R14
				end
			end
			ST_INV: begin
				if (wr_mode && mode_byte[0] == ~first_bit) begin
					next_state = ST_FIN; // see R02
				end else if (wr_mode || wr_unlock) begin
					seq_err = 1'b1;
					next_state = ST_IDLE; // see R05 R14
				end
			end
			ST_FIN: begin
				if (wr_mode && mode_byte[0] == first_bit) begin
					mode_commit = 1'b1; // see R03
					next_state = ST_IDLE; // see R04 R14
				end else if (wr_mode || wr_unlock) begin
					seq_err = 1'b1;
					next_state = ST_IDLE; // see R05 R14
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			state <= ST_IDLE;
			first_bit <= 1'b0;
			self_program_select_out <= `FMWG_MODE_RESET;
		end else if (ce_in) begin
			state <= next_state;
			if (state == ST_VAL && wr_mode) begin
				first_bit <= mode_byte[0];
			end
			if (mode_commit) begin
				// Software masks interrupts while this is set
				self_program_select_out <= mode_byte[0]; // see R03 R13
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Status flags: hardware set wins over software clear
	always @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			status <= `FMWG_STATUS_RESET; // see R08
		end else if (ce_in) begin
			if (wr_status) begin
				// Writing 1 does not set a flag, only 0 clears
				status[`FMWG_BIT_PROTECT] <= status[`FMWG_BIT_PROTECT] &
					stat_byte[`FMWG_BIT_PROTECT] | seq_err; // see R06 R11
				status[`FMWG_BIT_ERR_A] <= status[`FMWG_BIT_ERR_A] &
					stat_byte[`FMWG_BIT_ERR_A] | self_program_error_a_in; // see R07 R11
				status[`FMWG_BIT_ERR_B] <= status[`FMWG_BIT_ERR_B] &
					stat_byte[`FMWG_BIT_ERR_B] | self_program_error_b_in; // see R07 R11
			end else begin
				status[`FMWG_BIT_PROTECT] <= status[`FMWG_BIT_PROTECT] | seq_err; // see R05
				status[`FMWG_BIT_ERR_A] <= status[`FMWG_BIT_ERR_A] |
					self_program_error_a_in; // see R07
				status[`FMWG_BIT_ERR_B] <= status[`FMWG_BIT_ERR_B] |
					self_program_error_b_in; // see R07
			end
			status[7:3] <= 5'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port; unlock register is write-only
	always @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			rdata_out <= 8'h00;
		end else if (ce_in) begin
			if (rd_in && addr_in == `FMWG_ADDR_STATUS) begin
				rdata_out <= status;
			end else if (rd_in && addr_in == `FMWG_ADDR_MODE) begin
				rdata_out <= {7'h00, self_program_select_out};
			end else begin
				rdata_out <= 8'h00;
			end
		end
	end
endmodule // fmwg_guard
`default_nettype wire

// [tb/fmwg_guard_props.sv]
// Assertions for the flash mode write guard
`timescale 1ns/1ps
`default_nettype none
`include "fmwg_defs.vh"
module fmwg_guard_props (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [15:0] addr_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic bit_wr_in,
	input wire logic [2:0] bit_sel_in,
	input wire logic [7:0] wdata_in,
	input wire logic self_program_error_a_in,
	input wire logic self_program_error_b_in,
	input wire logic [7:0] rdata_out,
	input wire logic self_program_select_out,
	input wire logic [1:0] seq_state_out
);
	wire m = ce_in && wr_in && addr_in == `FMWG_ADDR_MODE;
	wire r = ce_in && rd_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_unlock;
		ce_in && wr_in && !bit_wr_in && addr_in == `FMWG_ADDR_UNLOCK
			&& wdata_in == `FMWG_UNLOCK_CODE && seq_state_out == 2'h0;
	endsequence
	a_reset_clear: assert property (disable iff (1'b0)
		!resetn_in && ce_in |=> rdata_out == 8'h00 && seq_state_out == 2'h0
		&& !self_program_select_out) else $error("reset left state");
	a_unlock_start: assert property (s_unlock |=> seq_state_out == 2'h1)
		else $error("unlock not taken");
	a_value_ignored: assert property (
		m && seq_state_out != 2'h3 |=> $stable(self_program_select_out))
		else $error("early mode write");
	a_fourth_only: assert property (
		$changed(self_program_select_out) && $past(resetn_in)
		|-> $past(seq_state_out) == 2'h3 && $past(m))
		else $error("mode changed off sequence");
	a_idle_error: assert property (
		m && seq_state_out == 2'h0 |=> seq_state_out == 2'h0) else $error("idle write moved");
	a_back_idle: assert property (
		m && seq_state_out == 2'h3 |=> seq_state_out == 2'h0) else $error("no return to idle");
	a_unlock_unread: assert property (
		r && addr_in == `FMWG_ADDR_UNLOCK |=> rdata_out == 8'h00) else $error("unlock readable");
	a_status_top: assert property (
		r && addr_in == `FMWG_ADDR_STATUS |=> rdata_out[7:3] == 5'h00) else $error("top bits set");
	a_ce_freeze: assert property (!ce_in |=> $stable(rdata_out)
		&& $stable(seq_state_out) && $stable(self_program_select_out))
		else $error("state moved while frozen");
endmodule // fmwg_guard_props
`default_nettype wire

// [tb/tb_fmwg_guard.sv]
// Testbench for the flash mode write guard
`timescale 1ns/1ps
`default_nettype none
`include "fmwg_defs.vh"
module tb_fmwg_guard;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, bw = 0, ea = 0, eb = 0, ce = 1;
	logic [15:0] ad = 0;
	logic [2:0] bs = 0;
	logic [7:0] wd = 0;
	wire [7:0] q;
	wire md;
	wire [1:0] st;
	int fails = 0;
	int samples_checked = 0;
	always #5 clk = ~clk;
	fmwg_guard fmwg_guard_i (.ref_clk_in(clk), .resetn_in(rst_n), .ce_in(ce),
		.addr_in(ad), .wr_in(wr), .rd_in(rd), .bit_wr_in(bw), .bit_sel_in(bs),
		.wdata_in(wd), .self_program_error_a_in(ea), .self_program_error_b_in(eb),
		.rdata_out(q), .self_program_select_out(md), .seq_state_out(st));
	task chk(input logic [7:0] g, e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task wrt(input logic [15:0] a, input logic [7:0] d, input logic b = 0, input logic [2:0] s = 0);
		@(posedge clk) #1;
		{ad, wd, bw, bs, wr} = {a, d, b, s, 1'b1};
		@(posedge clk) #1;
		wr = 0;
	endtask
	task rdc(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk) #1;
		{ad, rd} = {a, 1'b1};
		@(posedge clk) #1;
		rd = 0;
		chk(q, e);
	endtask
	task t_change(input logic [7:0] v);
		wrt(`FMWG_ADDR_UNLOCK, `FMWG_UNLOCK_CODE);
		wrt(`FMWG_ADDR_MODE, v);
		wrt(`FMWG_ADDR_MODE, ~v);
		chk({7'h00, md}, {7'h00, !v[0]});
		wrt(`FMWG_ADDR_MODE, v);
		chk({7'h00, md}, {7'h00, v[0]});
		rdc(`FMWG_ADDR_MODE, {7'h00, v[0]});
		chk({6'h00, st}, 8'h00);
	endtask
	task t_bad;
		wrt(`FMWG_ADDR_MODE, 8'h00);
		chk({7'h00, md}, 8'h01);
		rdc(`FMWG_ADDR_STATUS, 8'h01);
		wrt(`FMWG_ADDR_STATUS, 8'h00, 1, 0);
		rdc(`FMWG_ADDR_STATUS, 8'h00);
		wrt(`FMWG_ADDR_UNLOCK, `FMWG_UNLOCK_CODE);
		wrt(`FMWG_ADDR_MODE, 8'h00);
		wrt(`FMWG_ADDR_MODE, 8'h00);
		chk({6'h00, st}, 8'h00);
		rdc(`FMWG_ADDR_STATUS, 8'h01);
		wrt(`FMWG_ADDR_STATUS, 8'h00);
		chk({7'h00, md}, 8'h01);
	endtask
	task t_flags;
		@(posedge clk) #1;
		{ea, eb} = 2'h3;
		@(posedge clk) #1;
		{ea, eb} = 2'h0;
		rdc(`FMWG_ADDR_STATUS, 8'h06);
		wrt(`FMWG_ADDR_STATUS, 8'hff);
		rdc(`FMWG_ADDR_STATUS, 8'h06);
		wrt(`FMWG_ADDR_STATUS, 8'h00, 1, 1);
		rdc(`FMWG_ADDR_STATUS, 8'h04);
		wrt(`FMWG_ADDR_STATUS, 8'h00);
		rdc(`FMWG_ADDR_STATUS, 8'h00);
		rdc(`FMWG_ADDR_UNLOCK, 8'h00);
	endtask
	task t_reset;
		wrt(`FMWG_ADDR_UNLOCK, `FMWG_UNLOCK_CODE);
		{ea, eb} = 2'h3;
		@(posedge clk) #1;
		{rst_n, ea, eb} = 3'b000;
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		rdc(`FMWG_ADDR_STATUS, 8'h00);
		chk({7'h00, md}, 8'h00);
		chk({6'h00, st}, 8'h00);
	endtask
	task t_freeze;
		@(posedge clk) #1;
		{ce, ea} = 2'b01;
		wrt(`FMWG_ADDR_UNLOCK, `FMWG_UNLOCK_CODE);
		{ce, ea} = 2'b10;
		chk({6'h00, st}, 8'h00);
		rdc(`FMWG_ADDR_STATUS, 8'h00);
	endtask
	task give_verdict;
		if (fails == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_n = 1;
		t_reset();
		t_change(8'h01);
		t_bad();
		t_change(8'h00);
		t_flags();
		t_freeze();
		t_change(8'h01);
		t_reset();
		give_verdict();
	end
	initial begin
		#20000;
		fails++;
		give_verdict();
	end
endmodule // tb_fmwg_guard
bind fmwg_guard fmwg_guard_props fmwg_guard_props_i (.ref_clk_in(ref_clk_in),
	.resetn_in(resetn_in), .ce_in(ce_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
	.bit_wr_in(bit_wr_in), .bit_sel_in(bit_sel_in), .wdata_in(wdata_in),
	.self_program_error_a_in(self_program_error_a_in),
	.self_program_error_b_in(self_program_error_b_in), .rdata_out(rdata_out),
	.self_program_select_out(self_program_select_out), .seq_state_out(seq_state_out));
`default_nettype wire
